// ---- logic/mpwm_defines.svh ----
// register offsets, field positions and reset values of the match based modulation timer
`ifndef MPWM_DEFINES_SVH
`define MPWM_DEFINES_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MPWM_OFS_FLAGS 8'h00
`define MPWM_OFS_CTRL 8'h04
`define MPWM_OFS_COUNT 8'h08
`define MPWM_OFS_PRE_LIM 8'h0C
`define MPWM_OFS_PRE_CNT 8'h10
`define MPWM_OFS_MATCH_CTL 8'h14
`define MPWM_OFS_MATCH0 8'h18
`define MPWM_OFS_MATCH1 8'h1C
`define MPWM_OFS_MATCH2 8'h20
`define MPWM_OFS_MATCH3 8'h24
`define MPWM_OFS_CAP0 8'h28
`define MPWM_OFS_CAP1 8'h2C
`define MPWM_OFS_CAP2 8'h30
`define MPWM_OFS_CAP3 8'h34
`define MPWM_OFS_CAP_CTL 8'h38
`define MPWM_OFS_EXT_MATCH 8'h3C
`define MPWM_OFS_MATCH4 8'h40
`define MPWM_OFS_MATCH5 8'h44
`define MPWM_OFS_MATCH6 8'h48
`define MPWM_OFS_OUT_CTL 8'h4C
`define MPWM_OFS_RELEASE 8'h50
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MPWM_CTRL_RUN 0
`define MPWM_CTRL_RESET 1
`define MPWM_CTRL_MOD_EN 3
`define MPWM_OUT_SEL_LO 2
`define MPWM_OUT_EN_LO 9
`define MPWM_EXT_CTL_LO 7
`define MPWM_FLAG_CAP_LO 4
`define MPWM_FLAG_HI_LO 8
// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define MPWM_NUM_MATCH 7
`define MPWM_NUM_OUT 6
`define MPWM_NUM_CAP 4
`define MPWM_ZERO32 32'h0000_0000
`define MPWM_ONE32 32'h0000_0001
`define MPWM_EXT_NOP 2'h0
`define MPWM_EXT_LOW 2'h1
`define MPWM_EXT_HIGH 2'h2
`define MPWM_EXT_TOG 2'h3
`endif

// ---- logic/mpwm_pkg.sv ----
// types shared by the match based modulation timer
package mpwm_pkg;
    // ----------------------------------------------------------------
    // register port carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic wr; // one-cycle write strobe
        logic rd; // one-cycle read strobe
        logic [7:0] addr; // byte address
        logic [31:0] wdata; // write data
    } mpwm_req_t;
    // per match action bits: interrupt, reset, stop
    typedef struct packed {
        logic stop;
        logic rst;
        logic irq;
    } mpwm_mact_t;
endpackage

// ---- logic/mpwm_timer.sv ----
// match based modulation timer with prescaler, capture and six modulation outputs
//
// Local design decisions: the register offsets and the address-and-strobe port.
`include "mpwm_defines.svh"

// How it works
// - seven matches feed six modulation outputs
// - match zero restarts count, sets period
// - single-edge output set at cycle start
// - single-edge output cleared by own match
// - select bit picks previous match as set
// - channel one set always by match zero
// - double-edge values load at cycle boundary
// - zero acts like the cycle rate value
// - old rate value reused once on change
// - clear beats set when simultaneous
// - match above rate makes no event in modulation mode
// - released values load only at boundary
// - modulation off means plain timer
// - 32-bit counter with 32-bit prescaler
// - four capture channels snapshot counter
// - match may interrupt, stop, or reset counter
// - external match low, high, toggle, nothing
// - counter advances every limit plus one clocks
// - writing one clears a flag
// - match flag rises two clocks after match
module mpwm_timer (
    input wire logic clock, // 40 MHz clock
    input wire logic rst, // asynchronous, active high
    input wire mpwm_pkg::mpwm_req_t req, // register request
    output logic [31:0] rdata, // read data, cycle after read strobe
    input wire logic [3:0] cap_in, // capture inputs, synchronous
    output logic [3:0] ext_match, // external match outputs
    output logic irq, // any pending flag
    output logic [6:1] mod_out // modulation outputs
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0] timer_count_reg; // main counter
    logic [31:0] prescale_limit_reg; // prescale limit
    logic [31:0] pre_cnt_reg; // prescale counter
    logic [31:0] shadow_reg [0:6]; // software side match values
    logic [31:0] match_reg [0:6]; // live match values
    logic [31:0] cap_reg [0:3]; // capture values
    logic [6:0] release_reg; // released matches waiting for boundary
    logic [10:0] flags_reg; // pending flags, bits 4..7 hold captures
    logic [3:0] ctrl_reg; // run, reset, mode enable
    logic [20:0] mctl_reg; // three action bits per match
    logic [11:0] capctl_reg; // rise, fall, irq per capture
    logic [11:0] emr_reg; // ext state and action codes
    logic [14:0] pcr_reg; // edge mode select and output enables
    logic [3:0] cap_q_reg; // previous capture input level
    logic [6:0] matched_reg; // matches seen at last tick, feeds flags
    logic [6:1] rate_old_reg; // old double-edge value equalled the rate
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // action bits of one match from the control register
    function automatic mpwm_pkg::mpwm_mact_t mact(input logic [20:0] c, input int n);
        mact = c[n*3 +: 3] ;
    endfunction
    // match event: equal to count and not above the rate (out of range gives none)
    function automatic logic hit(input logic [31:0] v, input logic [31:0] cnt,
                                 input logic [31:0] rate);
        hit = (v == cnt) && (v <= rate);
    endfunction
    // offset of match register n
    function automatic logic [7:0] mofs(input int n);
        case (n)
            0: mofs = `MPWM_OFS_MATCH0;
            1: mofs = `MPWM_OFS_MATCH1;
            2: mofs = `MPWM_OFS_MATCH2;
            3: mofs = `MPWM_OFS_MATCH3;
            4: mofs = `MPWM_OFS_MATCH4;
            5: mofs = `MPWM_OFS_MATCH5;
            default: mofs = `MPWM_OFS_MATCH6;
        endcase
    endfunction
    // offset of capture register n
    function automatic logic [7:0] cofs(input int n);
        cofs = 8'(`MPWM_OFS_CAP0 + 8'(n * 4));
    endfunction
    // ----------------------------------------------------------------
    // tick and match detection
    // ----------------------------------------------------------------
    logic running; // counter enabled and not held in reset
    logic tick; // prescaler wraps, counter steps
    logic mod_en; // modulation mode on
    logic [6:0] hit_now; // match events at this count
    logic [6:0] hit_ev; // events that take effect this tick
    logic boundary; // cycle rate reached: next cycle begins
    logic do_reset; // any match asks for counter reset
    logic do_stop; // any match asks for stop
    logic [6:0] irq_on; // match asks for a pending flag
    logic [6:0] rst_on; // match asks for a counter reset
    always_comb begin
        mpwm_pkg::mpwm_mact_t act; // action bits of the match in hand
        act = '0;
        running = ctrl_reg[`MPWM_CTRL_RUN] && !ctrl_reg[`MPWM_CTRL_RESET];
        tick = running && (pre_cnt_reg == prescale_limit_reg);
        mod_en = ctrl_reg[`MPWM_CTRL_MOD_EN];
        do_reset = 1'b0;
        do_stop = 1'b0;
        for (int n = 0; n < `MPWM_NUM_MATCH; n++) begin
            // out of range only matters in modulation mode
            hit_now[n] = mod_en ? hit(match_reg[n], timer_count_reg, match_reg[0])
                                : (match_reg[n] == timer_count_reg);
            hit_ev[n] = tick && hit_now[n];
            act = mact(mctl_reg, n);
            irq_on[n] = act.irq;
            rst_on[n] = act.rst;
            if (hit_ev[n] && act.rst) begin
                do_reset = 1'b1;
            end
            if (hit_ev[n] && act.stop) begin
                do_stop = 1'b1;
            end
        end
        boundary = hit_ev[0];
    end
    // ----------------------------------------------------------------
    // prescaler and counter
    // ----------------------------------------------------------------
    // counter and prescaler reset together; software writes land directly
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            timer_count_reg <= `MPWM_ZERO32;
            pre_cnt_reg <= `MPWM_ZERO32;
        end else if (ctrl_reg[`MPWM_CTRL_RESET]) begin
            timer_count_reg <= `MPWM_ZERO32;
            pre_cnt_reg <= `MPWM_ZERO32;
        end else if (req.wr && req.addr == `MPWM_OFS_COUNT) begin
            timer_count_reg <= req.wdata;
        end else if (req.wr && req.addr == `MPWM_OFS_PRE_CNT) begin
            pre_cnt_reg <= req.wdata;
        end else if (running) begin
            if (tick) begin
                pre_cnt_reg <= `MPWM_ZERO32;
                // reset on match gives a full cycle to the match value
                timer_count_reg <= do_reset ? `MPWM_ZERO32
                                            : timer_count_reg + `MPWM_ONE32;
            end else begin
                pre_cnt_reg <= pre_cnt_reg + `MPWM_ONE32;
            end
        end
    end
    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    // stop on match drops the run bit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg <= 4'h0;
        end else if (req.wr && req.addr == `MPWM_OFS_CTRL) begin
            ctrl_reg <= req.wdata[3:0];
        end else if (do_stop) begin
            ctrl_reg[`MPWM_CTRL_RUN] <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // plain configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale_limit_reg <= `MPWM_ZERO32;
            mctl_reg <= 21'h0;
            capctl_reg <= 12'h0;
            pcr_reg <= 15'h0;
        end else if (req.wr) begin
            unique case (req.addr)
                `MPWM_OFS_PRE_LIM: prescale_limit_reg <= req.wdata;
                `MPWM_OFS_MATCH_CTL: mctl_reg <= req.wdata[20:0];
                `MPWM_OFS_CAP_CTL: capctl_reg <= req.wdata[11:0];
                `MPWM_OFS_OUT_CTL: pcr_reg <= req.wdata[14:0];
                default: ;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // match values: shadow, release, load at boundary
    // ----------------------------------------------------------------
    // in timer mode writes go live at once; in modulation mode they wait
    // for a release and the next cycle start, so no runt pulse is made
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int n = 0; n < `MPWM_NUM_MATCH; n++) begin
                shadow_reg[n] <= `MPWM_ZERO32;
                match_reg[n] <= `MPWM_ZERO32;
            end
            release_reg <= 7'h00;
        end else begin
            for (int n = 0; n < `MPWM_NUM_MATCH; n++) begin
                if (req.wr && req.addr == mofs(n)) begin
                    shadow_reg[n] <= req.wdata;
                    if (!mod_en) begin
                        match_reg[n] <= req.wdata;
                    end
                end else if (mod_en && boundary && release_reg[n]) begin
                    match_reg[n] <= shadow_reg[n];
                end
            end
            if (req.wr && req.addr == `MPWM_OFS_RELEASE) begin
                release_reg <= release_reg | req.wdata[6:0];
            end else if (boundary) begin
                release_reg <= 7'h00;
            end
        end
    end
    // ----------------------------------------------------------------
    // modulation outputs
    // ----------------------------------------------------------------
    // the output flip-flops follow the set/clear table; clear wins ties
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mod_out <= 6'h00;
            rate_old_reg <= 6'h00;
        end else if (!mod_en) begin
            mod_out <= 6'h00;
        end else if (tick) begin
            for (int n = 1; n <= `MPWM_NUM_OUT; n++) begin
                logic sel;
                logic set_ev;
                logic clr_ev;
                logic [31:0] sv;
                logic [31:0] cv;
                sel = pcr_reg[`MPWM_OUT_SEL_LO + n - 2] && (n != 1);
                sv = sel ? match_reg[n-1] : match_reg[0];
                cv = match_reg[n];
                set_ev = sel ? hit_now[n-1] : boundary;
                clr_ev = hit_now[n];
                if (sel) begin
                    // zero behaves like the rate: fires at the boundary
                    set_ev = set_ev || (boundary && sv == `MPWM_ZERO32);
                    clr_ev = clr_ev || (boundary && cv == `MPWM_ZERO32);
                    // an old value equal to the rate fires once more
                    if (boundary && rate_old_reg[n] && release_reg[n]) begin
                        set_ev = set_ev || (sv == match_reg[0]);
                    end
                end else if (boundary && cv == `MPWM_ZERO32) begin
                    clr_ev = 1'b1;
                end
                if (clr_ev) begin
                    mod_out[n] <= 1'b0;
                end else if (set_ev) begin
                    mod_out[n] <= 1'b1;
                end
                if (boundary) begin
                    rate_old_reg[n] <= (match_reg[n] == match_reg[0])
                                    && (shadow_reg[n] != `MPWM_ZERO32);
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // external match outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            emr_reg <= 12'h000;
        end else if (req.wr && req.addr == `MPWM_OFS_EXT_MATCH) begin
            emr_reg <= req.wdata[11:0];
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (hit_ev[n]) begin
                    unique case (emr_reg[4 + n*2 +: 2])
                        `MPWM_EXT_NOP: ;
                        `MPWM_EXT_LOW: emr_reg[n] <= 1'b0;
                        `MPWM_EXT_HIGH: emr_reg[n] <= 1'b1;
                        `MPWM_EXT_TOG: emr_reg[n] <= ~emr_reg[n];
                    endcase
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // capture channels
    // ----------------------------------------------------------------
    logic [3:0] cap_ev; // capture events this cycle
    always_comb begin
        for (int n = 0; n < `MPWM_NUM_CAP; n++) begin
            cap_ev[n] = (capctl_reg[n*3] && !cap_q_reg[n] && cap_in[n])
                     || (capctl_reg[n*3+1] && cap_q_reg[n] && !cap_in[n]);
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cap_q_reg <= 4'h0;
            for (int n = 0; n < `MPWM_NUM_CAP; n++) begin
                cap_reg[n] <= `MPWM_ZERO32;
            end
        end else begin
            cap_q_reg <= cap_in;
            for (int n = 0; n < `MPWM_NUM_CAP; n++) begin
                if (cap_ev[n]) begin
                    cap_reg[n] <= timer_count_reg;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // flags: set wins over the clearing write
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            matched_reg <= 7'h00;
            flags_reg <= 11'h000;
        end else begin
            for (int n = 0; n < `MPWM_NUM_MATCH; n++) begin
                matched_reg[n] <= hit_ev[n] && irq_on[n];
            end
            for (int b = 0; b < 11; b++) begin
                logic set;
                set = (b < 4) ? matched_reg[b]
                    : (b < `MPWM_FLAG_HI_LO) ? (cap_ev[b-4] && capctl_reg[(b-4)*3+2])
                    : matched_reg[b-4];
                if (set) begin
                    flags_reg[b] <= 1'b1;
                end else if (req.wr && req.addr == `MPWM_OFS_FLAGS && req.wdata[b]) begin
                    flags_reg[b] <= 1'b0;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // read path and registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata <= `MPWM_ZERO32;
            irq <= 1'b0;
            ext_match <= 4'h0;
        end else begin
            irq <= |flags_reg;
            ext_match <= emr_reg[3:0];
            rdata <= `MPWM_ZERO32;
            if (req.rd) begin
                unique case (req.addr)
                    `MPWM_OFS_FLAGS: rdata <= {21'h0, flags_reg};
                    `MPWM_OFS_CTRL: rdata <= {28'h0, ctrl_reg};
                    `MPWM_OFS_COUNT: rdata <= timer_count_reg;
                    `MPWM_OFS_PRE_LIM: rdata <= prescale_limit_reg;
                    `MPWM_OFS_PRE_CNT: rdata <= pre_cnt_reg;
                    `MPWM_OFS_MATCH_CTL: rdata <= {11'h0, mctl_reg};
                    `MPWM_OFS_MATCH0: rdata <= shadow_reg[0];
                    `MPWM_OFS_MATCH1: rdata <= shadow_reg[1];
                    `MPWM_OFS_MATCH2: rdata <= shadow_reg[2];
                    `MPWM_OFS_MATCH3: rdata <= shadow_reg[3];
                    `MPWM_OFS_CAP0: rdata <= cap_reg[0];
                    `MPWM_OFS_CAP1: rdata <= cap_reg[1];
                    `MPWM_OFS_CAP2: rdata <= cap_reg[2];
                    `MPWM_OFS_CAP3: rdata <= cap_reg[3];
                    `MPWM_OFS_CAP_CTL: rdata <= {20'h0, capctl_reg};
                    `MPWM_OFS_EXT_MATCH: rdata <= {20'h0, emr_reg};
                    `MPWM_OFS_MATCH4: rdata <= shadow_reg[4];
                    `MPWM_OFS_MATCH5: rdata <= shadow_reg[5];
                    `MPWM_OFS_MATCH6: rdata <= shadow_reg[6];
                    `MPWM_OFS_OUT_CTL: rdata <= {17'h0, pcr_reg};
                    `MPWM_OFS_RELEASE: rdata <= {25'h0, release_reg};
                    default: rdata <= `MPWM_ZERO32; // unmapped reads zero
                endcase
            end
        end
    end
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_flag_after_match: assert property (@(posedge clock) disable iff (rst)
        (hit_ev[0] && irq_on[0]) |-> ##2 flags_reg[0])
        else $error("match flag not raised after match");
    chk_prescale_step: assert property (@(posedge clock) disable iff (rst)
        (running && !tick && !req.wr) |=> $stable(timer_count_reg))
        else $error("counter stepped without prescale wrap");
    chk_clear_wins: assert property (@(posedge clock) disable iff (rst)
        (mod_en && tick && hit_now[1]) |=> !mod_out[1])
        else $error("output high after its clear match");
    chk_reset_low: assert property (@(posedge clock) disable iff (rst)
        !mod_en |=> mod_out == 6'h00)
        else $error("outputs not low outside modulation mode");
    chk_cycle_restart: assert property (@(posedge clock) disable iff (rst)
        (tick && hit_now[0] && rst_on[0] && !ctrl_reg[`MPWM_CTRL_RESET]
         && !req.wr) |=> timer_count_reg == `MPWM_ZERO32)
        else $error("count did not restart at rate match");
    chk_flag_clear: assert property (@(posedge clock) disable iff (rst)
        (req.wr && req.addr == `MPWM_OFS_FLAGS && req.wdata[1] && !matched_reg[1])
        |=> !flags_reg[1])
        else $error("flag not cleared by one");
    chk_single_set: assert property (@(posedge clock) disable iff (rst)
        (mod_en && boundary && !pcr_reg[`MPWM_OUT_SEL_LO] && !hit_now[2]
         && match_reg[2] != `MPWM_ZERO32) |=> mod_out[2])
        else $error("single-edge output not set at cycle start");
    chk_stop_run: assert property (@(posedge clock) disable iff (rst)
        (do_stop && !req.wr) |=> !ctrl_reg[`MPWM_CTRL_RUN])
        else $error("counter kept running after stop match");
endmodule // mpwm_timer

// ---- bench/mpwm_load.sv ----
// load model that integrates the on-time of each modulation output
module mpwm_load (
    input wire logic clock,
    input wire logic clear,
    input wire logic [6:1] mod_out,
    output int high_cnt [6:1]
);
    timeunit 1ns;
    timeprecision 100ps;
    // a plain resistive load: it only sees on-time, so the phase of a window does not matter
    always @(posedge clock) begin
        for (int i = 1; i <= 6; i++) begin
            high_cnt[i] <= clear ? 0 : high_cnt[i] + int'(mod_out[i] === 1'b1);
        end
    end
endmodule // mpwm_load

// ---- bench/tb_match_based_pwm_timer.sv ----
// self-checking bench for the match based modulation timer
`include "mpwm_defines.svh"
module tb_match_based_pwm_timer;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, rst, clear, irq;
    mpwm_pkg::mpwm_req_t req;
    logic [31:0] rdata, d;
    logic [3:0] cap_in, ext_match;
    logic [6:1] mod_out;
    int high_cnt [6:1];
    int num_errors = 0;
    int tests_run = 0;
    mpwm_timer i_mpwm_timer (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
        .cap_in(cap_in), .ext_match(ext_match), .irq(irq), .mod_out(mod_out));
    mpwm_load i_mpwm_load (.clock(clock), .clear(clear), .mod_out(mod_out), .high_cnt(high_cnt));
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clock);
        req <= '0;
    endtask
    // read data stands only in the cycle after the strobe, so sample it mid-cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clock);
        req <= '0;
        @(negedge clock);
        d = rdata;
    endtask
    // on-time over four periods of eleven clocks; e is ordered ch6 first
    task automatic duty(input int e [6:1]);
        @(posedge clock);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        repeat (44) @(posedge clock);
        #1;
        for (int i = 1; i <= 6; i++) begin
            check($sformatf("on time ch%0d", i), high_cnt[i], e[i] * 4);
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("outputs", 32'({irq, ext_match, mod_out}), 32'h0000_0000);
        rd(`MPWM_OFS_OUT_CTL);
        check("out ctl", d, 32'h0000_0000);
        rd(8'hFC);
        check("unmapped", d, 32'h0000_0000);
    endtask
    // limit 2 means one count every three clocks
    task automatic t_prescale();
        wr(`MPWM_OFS_PRE_LIM, 32'h0000_0002);
        wr(`MPWM_OFS_CTRL, 32'h0000_0001);
        repeat (30) @(posedge clock);
        rd(`MPWM_OFS_COUNT);
        check("count pace", d, 32'h0000_000A);
        wr(`MPWM_OFS_CTRL, 32'h0000_0002);
        wr(`MPWM_OFS_PRE_LIM, 32'h0000_0000);
    endtask
    // rate 10; ch4 double-edge from match3 to match4; ch5 above rate, ch6 zero
    task automatic t_pwm();
        wr(`MPWM_OFS_MATCH0, 32'h0000_000A);
        wr(`MPWM_OFS_MATCH1, 32'h0000_0004);
        wr(`MPWM_OFS_MATCH2, 32'h0000_0009);
        wr(`MPWM_OFS_MATCH3, 32'h0000_0002);
        wr(`MPWM_OFS_MATCH4, 32'h0000_0007);
        wr(`MPWM_OFS_MATCH5, 32'h0000_0014);
        wr(`MPWM_OFS_MATCH6, 32'h0000_0000);
        wr(`MPWM_OFS_MATCH_CTL, 32'h0000_0003);
        wr(`MPWM_OFS_OUT_CTL, 32'h0000_7E10);
        wr(`MPWM_OFS_CTRL, 32'h0000_0009);
        repeat (30) @(posedge clock);
        // single-edge on-time spans counts 0 to the match value inclusive
        duty('{0, 11, 5, 3, 10, 5});
        check("irq", 32'(irq), 32'h0000_0001);
    endtask
    // a held-back value must not show until it is released
    task automatic t_release();
        wr(`MPWM_OFS_MATCH1, 32'h0000_0006);
        duty('{0, 11, 5, 3, 10, 5});
        wr(`MPWM_OFS_RELEASE, 32'h0000_0002);
        repeat (30) @(posedge clock);
        duty('{0, 11, 5, 3, 10, 7});
    endtask
    // timer mode: match1 at 5 stops the count, which halts at 6, and drives its pin high, match3 toggles
    // its pin at 2; a rising capture input then snapshots the stopped count
    task automatic t_timer();
        wr(`MPWM_OFS_MATCH1, 32'h0000_0005);
        wr(`MPWM_OFS_MATCH_CTL, 32'h0000_0028);
        wr(`MPWM_OFS_EXT_MATCH, 32'h0000_0C80);
        wr(`MPWM_OFS_CAP_CTL, 32'h0000_0005);
        wr(`MPWM_OFS_CTRL, 32'h0000_0001);
        repeat (12) @(posedge clock);
        cap_in <= 4'h1;
        rd(`MPWM_OFS_CAP0);
        check("capture", d, 32'h0000_0006);
        rd(`MPWM_OFS_COUNT);
        check("stopped count", d, 32'h0000_0006);
        rd(`MPWM_OFS_FLAGS);
        check("flags", d, 32'h0000_0012);
        check("ext match", 32'(ext_match), 32'h0000_000A);
        cap_in <= 4'h0;
    endtask
    task automatic t_flags();
        wr(`MPWM_OFS_CTRL, 32'h0000_0002);
        repeat (3) @(posedge clock);
        check("outputs off", 32'(mod_out), 32'h0000_0000);
        wr(`MPWM_OFS_FLAGS, 32'h0000_0000);
        rd(`MPWM_OFS_FLAGS);
        check("flag kept", 32'(d[0]), 32'h0000_0001);
        wr(`MPWM_OFS_FLAGS, 32'h0000_07FF);
        rd(`MPWM_OFS_FLAGS);
        check("flags cleared", d, 32'h0000_0000);
        check("irq low", 32'(irq), 32'h0000_0000);
    endtask
    task automatic conclude();
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        rst = 1'b1;
        clear = 1'b0;
        req = '0;
        cap_in = 4'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        t_reset();
        t_prescale();
        t_pwm();
        t_release();
        t_flags();
        t_timer();
        conclude();
    end
endmodule // tb_match_based_pwm_timer
